// ### bench/nfc_flash_model.sv
`timescale 1ns/1ps
module nfc_flash_model (
  // timing reference
  input wire logic               clk,
  // host pins
  input wire nfc_pkg::nfc_pins_s pins,
  input wire logic [39:0]        id_bytes,
  input wire logic [15:0]        load_cyc,
  output logic [7:0]             io_in,
  output logic                   ready_busy_n
);
  import nfc_pkg::*;
  logic [7:0]  last_cmd = CMD_READ_SETUP;
  logic [1:0]  mode = 2'd0;
  logic [2:0]  nadr = 3'h0;
  logic [2:0]  idx = 3'h0;
  logic [11:0] col = 12'h0;
  logic [15:0] row = 16'h0;
  logic [15:0] busy = 16'h0;
  logic [7:0]  cur = 8'h0;
  logic [1:0]  hold = 2'h0;
  logic        we_p = 1'b1;
  logic        strobe_p = 1'b1;

  assign ready_busy_n = (busy == 16'h0);
  // released bus shows inverse of the last byte
  assign io_in = (hold != 2'h0 && !pins.ce_n) ? cur : ~cur;

  always @(posedge clk) begin
    we_p <= pins.we_n;
    strobe_p <= pins.read_strobe_n;
    if (busy != 16'h0) busy <= busy - 16'h1;
    if (!pins.read_strobe_n) hold <= 2'h3;
    else if (hold != 2'h0) hold <= hold - 2'h1;
    if (!we_p && pins.we_n && pins.cle) begin
      last_cmd <= pins.io_out;
      nadr     <= 3'h0;
      case (pins.io_out)
        CMD_ID: begin mode <= 2'd1; idx <= 3'h0; end
        CMD_STATUS: mode <= 2'd2;
        CMD_READ_SETUP, CMD_COL_CONFIRM: mode <= 2'd0;
        CMD_READ_CONFIRM: if (last_cmd == CMD_READ_SETUP) busy <= load_cyc;
        default: ;
      endcase
    end
    if (!we_p && pins.we_n && pins.ale) begin
      nadr <= nadr + 3'h1;
      case (nadr)
        3'h0: col[7:0] <= pins.io_out;
        3'h1: col[11:8] <= pins.io_out[3:0];
        3'h2: row[7:0] <= pins.io_out;
        3'h3: row[15:8] <= pins.io_out;
        default: ;
      endcase
    end
    if (strobe_p && !pins.read_strobe_n) begin
      if (mode == 2'd1) begin
        cur <= id_bytes[{idx, 3'b000} +: 8];
        idx <= idx + 3'h1;
      end else if (mode == 2'd2) cur <= {1'b1, ready_busy_n, 6'h00};
      else begin
        cur <= col[7:0] ^ row[7:0] ^ {4'h0, col[11:8]};
        col <= col + 12'h1;
      end
    end
  end
endmodule // nfc_flash_model

// ### bench/nfc_host_asserts.sv
`timescale 1ns/1ps
module nfc_host_asserts #(
  parameter int LOAD_LIMIT_CYC = nfc_pkg::ARRAY_LOAD_CYC
) (
  // clock and reset
  input wire logic               clk,
  input wire logic               resetn,
  // user side
  input wire logic               req_valid,
  input wire nfc_pkg::nfc_req_s  req_in,
  input wire logic               req_ready,
  input wire logic               done,
  input wire logic               load_timeout,
  input wire logic [7:0]         status,
  input wire nfc_pkg::nfc_id_s   id_info,
  input wire logic               data_valid,
  input wire logic [7:0]         data,
  input wire logic               data_ready,
  // flash side
  input wire nfc_pkg::nfc_pins_s pins,
  input wire logic [7:0]         io_in,
  input wire logic               ready_busy_n
);
  import nfc_pkg::*;
  logic        we_p;
  logic [7:0]  last_cmd;
  logic [2:0]  nadr;
  logic [15:0] since;
  wire         cmd_fall = we_p && !pins.we_n && pins.cle;

  // last command, address cycles since it, cycles since confirm
  always_ff @(posedge clk) begin
    if (!resetn) begin
      we_p     <= 1'b1;
      last_cmd <= CMD_READ_SETUP;
      nadr     <= 3'h0;
      since    <= 16'h0;
    end else begin
      we_p <= pins.we_n;
      if (since != 16'hFFFF) since <= since + 16'h1;
      if (we_p && !pins.we_n && pins.ale) nadr <= nadr + 3'h1;
      if (cmd_fall) begin
        last_cmd <= pins.io_out;
        nadr     <= 3'h0;
        if (pins.io_out == CMD_READ_CONFIRM) since <= 16'h0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_we_pulse: assert property ($fell(pins.we_n) |-> !pins.we_n [*3] ##1 pins.we_n)
    else $error("write strobe width wrong");
  a_write_hold: assert property ($fell(pins.we_n) |=> $stable({pins.cle, pins.ale, pins.io_oe, pins.io_out}) [*5])
    else $error("write qualifiers moved during strobe");
  a_addr_count: assert property (cmd_fall && pins.io_out == CMD_READ_CONFIRM |-> nadr == 3'h4)
    else $error("confirm without four address cycles");
  a_setup_first: assert property (cmd_fall && pins.io_out == CMD_READ_CONFIRM |-> last_cmd == CMD_READ_SETUP)
    else $error("confirm without setup held");
  a_jump_cols: assert property (cmd_fall && pins.io_out == CMD_COL_CONFIRM |-> nadr == 3'h2 && last_cmd == CMD_COL_JUMP)
    else $error("column jump sequence wrong");
  a_id_address: assert property (cmd_fall && pins.io_out == CMD_ID |->
      ##[6:20] ($fell(pins.we_n) && pins.ale && pins.io_out == ID_ADDR))
    else $error("identifier command lacks its address");
  a_strobe_pulse: assert property ($fell(pins.read_strobe_n) |->
      !pins.read_strobe_n [*8] ##1 pins.read_strobe_n [*3])
    else $error("read strobe timing wrong");
  a_bus_turn: assert property (!pins.read_strobe_n |-> !pins.io_oe && !pins.ce_n && pins.we_n)
    else $error("bus driven during read strobe");
  a_data_wait: assert property ($fell(pins.read_strobe_n) |-> last_cmd == CMD_STATUS || $past(ready_busy_n, 2))
    else $error("data strobe while busy");
  a_no_both: assert property (!(pins.cle && pins.ale))
    else $error("command and address latch together");
  a_timeout_late: assert property ($rose(load_timeout) |-> since >= LOAD_LIMIT_CYC)
    else $error("load timeout too early");
endmodule // nfc_host_asserts

bind nfc_host nfc_host_asserts #(.LOAD_LIMIT_CYC(LOAD_LIMIT_CYC)) nfc_host_asserts_i (
  .clk(clk), .resetn(resetn), .req_valid(req_valid), .req_in(req_in), .req_ready(req_ready),
  .done(done), .load_timeout(load_timeout), .status(status), .id_info(id_info),
  .data_valid(data_valid), .data(data), .data_ready(data_ready), .pins(pins), .io_in(io_in),
  .ready_busy_n(ready_busy_n));

// ### bench/nfc_host_tb.sv
`timescale 1ns/1ps
module nfc_host_tb;
  import nfc_pkg::*;
  localparam int LIMIT = 200;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        req_valid = 1'b0;
  nfc_req_s    req_in = '0;
  logic        data_ready = 1'b0;
  logic [39:0] id_bytes = '0;
  logic [15:0] load_cyc = 16'h003C;
  logic        req_ready, done, load_timeout, data_valid, ready_busy_n;
  logic [7:0]  status, data, io_in;
  nfc_id_s     id_info;
  nfc_pins_s   pins;
  logic [15:0] row = 16'h0;
  logic [39:0] idb;
  logic [65:0] note;
  logic [11:0] jc[3] = '{12'd2111, 12'd17, 12'd2112};
  logic [7:0]  exp_data[$];
  logic [65:0] exp_done[$];
  int          bad_count = 0;
  int          total_checks = 0;
  int          seed = 32'h54B3;
  int          thr = 8;

  always #2 clk = ~clk;
  always @(posedge clk) data_ready <= ($random(seed) & 7) < thr;

  nfc_host #(.LOAD_LIMIT_CYC(LIMIT)) nfc_host_i (
    .clk(clk), .resetn(resetn), .req_valid(req_valid), .req_in(req_in), .req_ready(req_ready),
    .done(done), .load_timeout(load_timeout), .status(status), .id_info(id_info),
    .data_valid(data_valid), .data(data), .data_ready(data_ready),
    .pins(pins), .io_in(io_in), .ready_busy_n(ready_busy_n));
  nfc_flash_model nfc_flash_model_i (
    .clk(clk), .pins(pins), .id_bytes(id_bytes), .load_cyc(load_cyc), .io_in(io_in),
    .ready_busy_n(ready_busy_n));

  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    total_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  function automatic nfc_id_s decode(input logic [39:0] b);
    nfc_id_s e;
    e.maker = b[7:0];
    e.device = b[15:8];
    e.chips = 4'h1 << b[17:16];
    e.cell_levels = 5'h02 << b[19:18];
    e.prog_pages = 4'h1 << b[21:20];
    e.interleave = b[22];
    e.cache_prog = b[23];
    e.page_kb = 4'h1 << b[25:24];
    e.spare16 = b[26];
    e.access_rsvd = b[27];
    e.block_kb = 10'h040 << b[29:28];
    e.x16 = b[30];
    e.access_25ns = b[31] & ~b[27];
    e.ecc_bits = (b[33:32] == 2'h3) ? 3'h0 : 3'h4 >> b[33:32];
    e.planes = 4'h1 << b[35:34];
    e.plane_size_log2 = b[38:36];
    e.rsvd_ok = ~b[39];
    return e;
  endfunction

  task automatic run(input nfc_op_e o, input logic [11:0] c, input logic [11:0] n,
                     input logic p, input logic om, input logic [65:0] nt);
    int w;
    req_in <= '{o, c, row, n, p, om};
    exp_done.push_back(nt);
    req_valid <= 1'b1;
    @(posedge clk);
    while (req_ready !== 1'b1) @(posedge clk);
    req_valid <= 1'b0;
    w = 0;
    do begin
      @(posedge clk);
      w++;
    end while (done !== 1'b1 && w < 5000);
    if (w >= 5000) begin
      bad_count++;
      stop_test();
    end
  endtask

  // expected bytes run from col to the count or the page end
  task automatic page(input nfc_op_e o, input logic [11:0] c, input logic [11:0] n,
                      input logic p, input logic om, input logic slow);
    int lim;
    int k;
    lim = int'(PAGE_BYTES) - int'(c);
    k = (n == 12'h0 || int'(n) > lim) ? lim : int'(n);
    for (int i = 0; i < k && !slow; i++) exp_data.push_back(pat(12'(int'(c) + i)));
    run(o, c, n, p, om, {2'b00, 63'h0, slow});
  endtask

  function automatic logic [7:0] pat(input logic [11:0] c);
    return c[7:0] ^ row[7:0] ^ {4'h0, c[11:8]};
  endfunction

  always @(posedge clk) begin
    if (resetn && data_valid === 1'b1 && data_ready) begin
      if (exp_data.size() != 0) check(data, exp_data.pop_front());
      else check(data, 64'h100);
    end
    if (resetn && done === 1'b1 && exp_done.size() != 0) begin
      note = exp_done.pop_front();
      case (note[65:64])
        2'b00: check(load_timeout, note[63:0]);
        2'b01: check(status, note[63:0]);
        default: check(id_info, note[63:0]);
      endcase
    end
  end

  initial begin
    #200000;
    bad_count++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    row = 16'($random(seed));
    page(OP_PAGE, 12'($random(seed) & 32'h3FF), 12'd9, 1'b0, 1'b1, 1'b0);
    for (int k = 0; k < 6; k++) begin
      idb = 40'({$random(seed), $random(seed)});
      id_bytes <= idb;
      run(OP_ID, 12'h0, 12'h0, 1'b0, 1'b0, {2'b10, 4'h0, decode(idb)});
    end
    thr = 1;
    page(OP_PAGE, 12'd2040, 12'd0, 1'b1, 1'b1, 1'b0);
    thr = 4;
    foreach (jc[i]) page(OP_JUMP, jc[i], 12'd3, 1'b0, 1'b0, 1'b0);
    run(OP_STATUS, 12'h0, 12'h0, 1'b0, 1'b0, {2'b01, 64'hC0});
    thr = 8;
    row = 16'($random(seed));
    page(OP_PAGE, 12'h0, 12'd6, 1'b0, 1'b0, 1'b0);
    load_cyc <= 16'd400;
    page(OP_PAGE, 12'd5, 12'd3, 1'b0, 1'b0, 1'b1);
    repeat (50) @(posedge clk);
    check(64'(exp_data.size()), 64'h0);
    stop_test();
  end
endmodule // nfc_host_tb

// ### hw/nfc_buf2.sv
`timescale 1ns/1ps
module nfc_buf2 #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // draining side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  logic [WIDTH-1:0] tail;
  logic             tail_v;
  logic [WIDTH-1:0] next_head;
  logic             next_head_v;
  logic [WIDTH-1:0] next_tail;
  logic             next_tail_v;

  assign in_ready = !tail_v;

  always_comb begin
    next_head   = out_data;
    next_head_v = out_valid;
    next_tail   = tail;
    next_tail_v = tail_v;
    if (out_valid && out_ready) begin
      next_head   = tail;
      next_head_v = tail_v;
      next_tail_v = 1'b0;
    end
    if (in_valid && !tail_v) begin
      if (!next_head_v) begin
        next_head   = in_data;
        next_head_v = 1'b1;
      end else begin
        next_tail   = in_data;
        next_tail_v = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      out_data  <= '0;
      out_valid <= 1'b0;
      tail      <= '0;
      tail_v    <= 1'b0;
    end else begin
      out_data  <= next_head;
      out_valid <= next_head_v;
      tail      <= next_tail;
      tail_v    <= next_tail_v;
    end
  end

endmodule // nfc_buf2

// ### hw/nfc_host.sv
// What this block does
// - 90h yields maker, device, three geometry bytes
// - page read: 00h, four addresses, 30h
// - first read after power-up may skip 00h
// - strobe data only after ready returns
// - each strobe fall yields next byte, at least 44ns apart
// - column jump repeatable within loaded page
// - status 70h allowed right after 30h
`timescale 1ns/1ps
module nfc_host #(
  parameter int LOAD_LIMIT_CYC = nfc_pkg::ARRAY_LOAD_CYC
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               resetn,
  // user requests
  input  wire logic               req_valid,
  input  wire nfc_pkg::nfc_req_s  req_in,
  output logic                    req_ready,
  output logic                    done,
  output logic                    load_timeout,
  output logic [7:0]              status,
  output nfc_pkg::nfc_id_s        id_info,
  // page data stream
  output logic                    data_valid,
  output logic [7:0]              data,
  input  wire logic               data_ready,
  // flash pins
  output nfc_pkg::nfc_pins_s      pins,
  input  wire logic [7:0]         io_in,
  input  wire logic               ready_busy_n
);
  import nfc_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_WR, S_GAP, S_WB, S_RDY, S_RD, S_DONE} nfc_state_e;

  nfc_state_e              state;
  nfc_state_e              next_state;
  nfc_ph_e                 ph;
  nfc_ph_e                 next_ph;
  nfc_req_s                req;
  nfc_req_s                next_req;
  logic [2:0]              idx;
  logic [2:0]              next_idx;
  logic [7:0]              cnt;
  logic [7:0]              next_cnt;
  logic                    low;
  logic                    next_low;
  logic [11:0]             remain;
  logic [11:0]             next_remain;
  logic [15:0]             busy_cnt;
  logic [15:0]             next_busy_cnt;
  logic                    fresh;
  logic                    next_fresh;
  logic                    omit;
  logic                    next_omit;
  logic [4:0][7:0]         id_raw;
  logic [4:0][7:0]         next_id_raw;
  nfc_pins_s               next_pins;
  nfc_id_s                 next_id_info;
  logic                    next_req_ready;
  logic                    next_done;
  logic                    next_timeout;
  logic [7:0]              next_status;
  logic [7:0]              io_s1;
  logic [7:0]              io_s2;
  logic                    rb_s1;
  logic                    rb_s2;
  logic                    push_valid;
  logic                    push_ready;
  logic [7:0]              push_data;
  nfc_step_s               step;
  logic [11:0]             span;

  function automatic nfc_step_s step_of(input nfc_op_e op, input nfc_ph_e p, input logic [2:0] i,
                                        input nfc_req_s r, input logic skip);
    nfc_step_s  s;
    logic [2:0] k;
    s = '{1'b1, 1'b1, CMD_STATUS};
    k = i + {2'b00, skip};
    if (p == PH_POLL) begin
      s = '{1'b1, 1'b1, CMD_STATUS};
    end else if (p == PH_RESUME) begin
      s = '{1'b1, 1'b1, CMD_READ_SETUP};
    end else begin
      unique case (op)
        OP_ID:     s = (i == 3'h0) ? nfc_step_s'{1'b0, 1'b1, CMD_ID} : nfc_step_s'{1'b1, 1'b0, ID_ADDR};
        OP_STATUS: s = '{1'b1, 1'b1, CMD_STATUS};
        OP_JUMP: begin
          unique case (i)
            3'h0:    s = '{1'b0, 1'b1, CMD_COL_JUMP};
            3'h1:    s = '{1'b0, 1'b0, r.col[7:0]};
            3'h2:    s = '{1'b0, 1'b0, {4'h0, r.col[11:8]}};
            default: s = '{1'b1, 1'b1, CMD_COL_CONFIRM};
          endcase
        end
        OP_PAGE: begin
          unique case (k)
            3'h0:    s = '{1'b0, 1'b1, CMD_READ_SETUP};
            3'h1:    s = '{1'b0, 1'b0, r.col[7:0]};
            3'h2:    s = '{1'b0, 1'b0, {4'h0, r.col[11:8]}};
            3'h3:    s = '{1'b0, 1'b0, r.row[7:0]};
            3'h4:    s = '{1'b0, 1'b0, r.row[15:8]};
            default: s = '{1'b1, 1'b1, CMD_READ_CONFIRM};
          endcase
        end
      endcase
    end
    return s;
  endfunction

  function automatic nfc_id_s decode(input logic [4:0][7:0] b);
    nfc_id_s d;
    d.maker           = b[0];
    d.device          = b[1];
    d.chips           = 4'h1 << b[2][ID3_CHIPS_LSB +: 2];
    d.cell_levels     = 5'h02 << b[2][ID3_CELL_LSB +: 2];
    d.prog_pages      = 4'h1 << b[2][ID3_PAGES_LSB +: 2];
    d.interleave      = b[2][ID3_ILV_BIT];
    d.cache_prog      = b[2][ID3_CACHE_BIT];
    d.page_kb         = 4'h1 << b[3][ID4_PAGE_LSB +: 2];
    d.block_kb        = 10'h040 << b[3][ID4_BLOCK_LSB +: 2];
    d.spare16         = b[3][ID4_SPARE_BIT];
    d.x16             = b[3][ID4_ORG_BIT];
    d.access_25ns     = b[3][ID4_ACC_HI_BIT] && !b[3][ID4_ACC_LO_BIT];
    d.access_rsvd     = b[3][ID4_ACC_LO_BIT];
    unique case (b[4][ID5_ECC_LSB +: 2])
      2'h0:    d.ecc_bits = 3'h4;
      2'h1:    d.ecc_bits = 3'h2;
      2'h2:    d.ecc_bits = 3'h1;
      default: d.ecc_bits = 3'h0;
    endcase
    d.planes          = 4'h1 << b[4][ID5_PLANES_LSB +: 2];
    d.plane_size_log2 = b[4][ID5_PSIZE_LSB +: 3];
    d.rsvd_ok         = !b[4][ID5_RSVD_BIT];
    return d;
  endfunction

  assign step = step_of(req.op, ph, idx, req, omit);
  assign span = (req_in.col < PAGE_BYTES) ? PAGE_BYTES - req_in.col : 12'h000;

  always_comb begin
    next_state     = state;
    next_ph        = ph;
    next_req       = req;
    next_idx       = idx;
    next_cnt       = (cnt != 8'h00) ? cnt - 8'h01 : 8'h00;
    next_low       = low;
    next_remain    = remain;
    next_busy_cnt  = busy_cnt;
    next_fresh     = fresh;
    next_omit      = omit;
    next_id_raw    = id_raw;
    next_id_info   = id_info;
    next_pins      = pins;
    next_req_ready = 1'b0;
    next_done      = 1'b0;
    next_timeout   = load_timeout;
    next_status    = status;
    push_valid     = 1'b0;
    push_data      = io_s2;
    unique case (state)
      S_IDLE: begin
        next_req_ready = 1'b1;
        if (req_valid && req_ready) begin
          next_req       = req_in;
          next_req_ready = 1'b0;
          next_ph        = PH_MAIN;
          next_idx       = 3'h0;
          next_fresh     = 1'b0;
          next_omit      = fresh && req_in.omit_setup && (req_in.op == OP_PAGE);
          next_timeout   = 1'b0;
          next_busy_cnt  = 16'h0000;
          next_low       = 1'b0;
          next_cnt       = 8'h00;
          next_pins.ce_n = 1'b0;
          next_state     = S_WR;
          unique case (req_in.op)
            OP_ID:     next_remain = ID_BYTES;
            OP_STATUS: next_remain = ONE_BYTE;
            default:   next_remain = (req_in.count == 12'h000 || req_in.count > span) ? span : req_in.count;
          endcase
        end
      end
      S_WR: begin
        if (cnt == 8'h00) begin
          if (!low) begin
            next_low         = 1'b1;
            next_cnt         = 8'(WE_LOW_CYC - 1);
            next_pins.we_n   = 1'b0;
            next_pins.cle    = step.is_cmd;
            next_pins.ale    = !step.is_cmd;
            next_pins.io_oe  = 1'b1;
            next_pins.io_out = step.val;
          end else if (pins.we_n == 1'b0) begin
            next_pins.we_n = 1'b1;
            next_cnt       = 8'(WE_HIGH_CYC - 1);
          end else begin
            next_low        = 1'b0;
            next_pins.cle   = 1'b0;
            next_pins.ale   = 1'b0;
            next_pins.io_oe = 1'b0;
            next_idx        = idx + 3'h1;
            if (step.last) begin
              next_idx = 3'h0;
              if (req.op == OP_PAGE && ph == PH_MAIN) begin
                next_state = S_WB;
                next_cnt   = 8'(WB_CYC - 1);
              end else begin
                next_state = S_GAP;
                next_cnt   = 8'(WHR_CYC - 1);
              end
            end
          end
        end
      end
      S_GAP: begin
        if (cnt == 8'h00) begin
          next_state = S_RD;
        end
      end
      S_WB: begin
        next_busy_cnt = busy_cnt + 16'h0001;
        if (cnt == 8'h00) begin
          if (req.poll) begin
            next_ph    = PH_POLL;
            next_state = S_WR;
          end else begin
            next_state = S_RDY;
          end
        end
      end
      S_RDY: begin
        next_busy_cnt = busy_cnt + 16'h0001;
        if (rb_s2) begin
          next_state = S_GAP;
          next_cnt   = 8'(WHR_CYC - 1);
        end else if (busy_cnt >= 16'(LOAD_LIMIT_CYC)) begin
          next_timeout = 1'b1;
          next_state   = S_DONE;
        end
      end
      S_RD: begin
        if (ph == PH_POLL) begin
          next_busy_cnt = busy_cnt + 16'h0001;
        end
        if (cnt == 8'h00) begin
          if (!low) begin
            if (remain == 12'h000) begin
              next_state = S_DONE;
            end else if (ph == PH_POLL && busy_cnt >= 16'(LOAD_LIMIT_CYC)) begin
              next_timeout = 1'b1;
              next_state   = S_DONE;
            end else if (push_ready || req.op == OP_ID || ph == PH_POLL || req.op == OP_STATUS) begin
              next_low                = 1'b1;
              next_pins.read_strobe_n = 1'b0;
              next_cnt                = 8'(RD_LOW_CYC - 1);
            end
          end else begin
            next_low                = 1'b0;
            next_pins.read_strobe_n = 1'b1;
            next_cnt                = 8'(RD_HIGH_CYC - 1);
            if (ph == PH_POLL) begin
              next_status = io_s2;
              if (io_s2[STAT_READY_BIT]) begin
                next_ph    = PH_RESUME;
                next_state = S_WR;
              end
            end else begin
              next_remain = remain - 12'h001;
              unique case (req.op)
                OP_ID:     next_id_raw[3'(ID_BYTES - remain)] = io_s2;
                OP_STATUS: next_status = io_s2;
                default:   push_valid = 1'b1;
              endcase
            end
          end
        end
      end
      S_DONE: begin
        next_pins.ce_n = 1'b1;
        next_done      = 1'b1;
        next_req_ready = 1'b1;
        next_state     = S_IDLE;
        if (req.op == OP_ID) begin
          next_id_info = decode(id_raw);
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    io_s1 <= io_in;
    io_s2 <= io_s1;
    rb_s1 <= ready_busy_n;
    rb_s2 <= rb_s1;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state        <= S_IDLE;
      ph           <= PH_MAIN;
      req          <= '0;
      idx          <= 3'h0;
      cnt          <= 8'h00;
      low          <= 1'b0;
      remain       <= 12'h000;
      busy_cnt     <= 16'h0000;
      fresh        <= 1'b1;
      omit         <= 1'b0;
      id_raw       <= '0;
      id_info      <= '0;
      pins         <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00};
      req_ready    <= 1'b0;
      done         <= 1'b0;
      load_timeout <= 1'b0;
      status       <= 8'h00;
    end else begin
      state        <= next_state;
      ph           <= next_ph;
      req          <= next_req;
      idx          <= next_idx;
      cnt          <= next_cnt;
      low          <= next_low;
      remain       <= next_remain;
      busy_cnt     <= next_busy_cnt;
      fresh        <= next_fresh;
      omit         <= next_omit;
      id_raw       <= next_id_raw;
      id_info      <= next_id_info;
      pins         <= next_pins;
      req_ready    <= next_req_ready;
      done         <= next_done;
      load_timeout <= next_timeout;
      status       <= next_status;
    end
  end

  nfc_buf2 #(
    .WIDTH(8)
  ) u_buf (
    .clk      (clk),
    .resetn   (resetn),
    .in_valid (push_valid),
    .in_data  (push_data),
    .in_ready (push_ready),
    .out_valid(data_valid),
    .out_data (data),
    .out_ready(data_ready)
  );

endmodule // nfc_host

// ### hw/nfc_pkg.sv
package nfc_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS  = 4;
  localparam int WE_LOW_NS      = 12;
  localparam int WE_HIGH_NS     = 10;
  localparam int RD_LOW_NS      = 30;
  localparam int RD_HIGH_NS     = 10;
  localparam int WHR_NS         = 60;
  localparam int WB_NS          = 100;
  localparam int ARRAY_LOAD_NS  = 25000;
  localparam int WE_LOW_CYC     = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_HIGH_CYC    = (WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_LOW_CYC     = (RD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_HIGH_CYC    = (RD_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WHR_CYC        = (WHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WB_CYC         = (WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ARRAY_LOAD_CYC = ARRAY_LOAD_NS / CLK_PERIOD_NS;

  // command codes
  localparam logic [7:0] CMD_READ_SETUP   = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_ID           = 8'h90;
  localparam logic [7:0] ID_ADDR          = 8'h00;
  localparam logic [7:0] CMD_COL_JUMP     = 8'h05;
  localparam logic [7:0] CMD_COL_CONFIRM  = 8'hE0;
  localparam logic [7:0] CMD_STATUS       = 8'h70;

  // geometry and status
  localparam logic [11:0] PAGE_BYTES     = 12'h840;
  localparam logic [11:0] ID_BYTES       = 12'h005;
  localparam logic [11:0] ONE_BYTE       = 12'h001;
  localparam int          STAT_READY_BIT = 6;

  // identifier field positions
  localparam int ID3_CHIPS_LSB  = 0;
  localparam int ID3_CELL_LSB   = 2;
  localparam int ID3_PAGES_LSB  = 4;
  localparam int ID3_ILV_BIT    = 6;
  localparam int ID3_CACHE_BIT  = 7;
  localparam int ID4_PAGE_LSB   = 0;
  localparam int ID4_SPARE_BIT  = 2;
  localparam int ID4_ACC_LO_BIT = 3;
  localparam int ID4_BLOCK_LSB  = 4;
  localparam int ID4_ORG_BIT    = 6;
  localparam int ID4_ACC_HI_BIT = 7;
  localparam int ID5_ECC_LSB    = 0;
  localparam int ID5_PLANES_LSB = 2;
  localparam int ID5_PSIZE_LSB  = 4;
  localparam int ID5_RSVD_BIT   = 7;

  typedef enum logic [1:0] {OP_ID, OP_PAGE, OP_JUMP, OP_STATUS} nfc_op_e;
  typedef enum logic [1:0] {PH_MAIN, PH_POLL, PH_RESUME} nfc_ph_e;

  typedef struct packed {
    nfc_op_e     op;
    logic [11:0] col;
    logic [15:0] row;
    logic [11:0] count;
    logic        poll;
    logic        omit_setup;
  } nfc_req_s;

  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       read_strobe_n;
    logic       io_oe;
    logic [7:0] io_out;
  } nfc_pins_s;

  typedef struct packed {
    logic       last;
    logic       is_cmd;
    logic [7:0] val;
  } nfc_step_s;

  typedef struct packed {
    logic [7:0] maker;
    logic [7:0] device;
    logic [3:0] chips;
    logic [4:0] cell_levels;
    logic [3:0] prog_pages;
    logic       interleave;
    logic       cache_prog;
    logic [3:0] page_kb;
    logic [9:0] block_kb;
    logic       spare16;
    logic       x16;
    logic       access_25ns;
    logic       access_rsvd;
    logic [2:0] ecc_bits;
    logic [3:0] planes;
    logic [2:0] plane_size_log2;
    logic       rsvd_ok;
  } nfc_id_s;

endpackage
